// ==== pwr_pkg.sv ====
// Package of constants and carrier types for the power-mode controller
// Operation
// - Bit 10 of 1Fh enables power saving
// - Power saving needs autoneg on, no link
// - Power saving keeps only transmitter, detector, PLL
// - Power saving enable resets to disabled
// - Bit 11 of 18h low enables sleep
// - Bit 4 of 10h stops PLL in sleep
// - Sleep keeps sending periodic link pulses
// - Sleep enable resets to disabled
// - Bit 11 of 0h powers down, management stays
// - Clearing bit 11 of 0h leaves power-down
// - Bit 5 of 11h selects slow oscillator
// - Slow oscillator plus power-down is lowest
`default_nettype none
package pwr_pkg;
   // ==========================================================
   // Register numbers and field positions
   localparam logic [4:0] REG_BASIC_CTRL = 5'h00;
   localparam logic [4:0] REG_OP_MODE = 5'h10;
   localparam logic [4:0] REG_OSC_CTRL = 5'h11;
   localparam logic [4:0] REG_SLEEP_CTRL = 5'h18;
   localparam logic [4:0] REG_PHY_CTRL2 = 5'h1F;
   localparam int BIT_SOFT_RESET = 15;
   localparam int BIT_POWER_DOWN = 11;
   localparam int BIT_PLL_AUTO_OFF = 4;
   localparam int BIT_SLOW_OSC = 5;
   localparam int BIT_SLEEP_DISABLE_N = 11;
   localparam int BIT_POWER_SAVE = 10;
   // ==========================================================
   // Reset values
   localparam logic RST_POWER_DOWN = 1'h0;
   localparam logic RST_PLL_AUTO_OFF = 1'h0;
   localparam logic RST_SLOW_OSC = 1'h0;
   localparam logic RST_SLEEP_DISABLE_N = 1'h1;
   localparam logic RST_POWER_SAVE = 1'h0;
   // ==========================================================
   // Timing: link pulse period in sleep and software reset length
   localparam int CLK_MHZ = 25;
   localparam int PULSE_PERIOD_MS = 16;
   localparam int PULSE_PERIOD_CYCLES = PULSE_PERIOD_MS * 1000 * CLK_MHZ;
   localparam int SOFT_RESET_CYCLES = 16;
   // ==========================================================
   // Register write from the management frame decoder
   typedef struct packed {
      logic valid;
      logic [4:0] addr;
      logic [15:0] data;
   } reg_write_t;
   // Enables for the transceiver blocks
   typedef struct packed {
      logic transmitter;
      logic energy_detect;
      logic pll;
      logic receiver;
      logic digital_core;
      logic slow_osc_sel;
   } block_enable_t;
   typedef enum logic [2:0] {
      ST_NORMAL,
      ST_POWER_SAVE,
      ST_SLEEP,
      ST_POWER_DOWN,
      ST_SOFT_RESET
   } power_state_t;
endpackage
`default_nettype wire

// ==== pulse_timer.sv ====
// Periodic one-cycle pulse generator for link pulses during sleep
`default_nettype none
module pulse_timer #(
   parameter int PERIOD = pwr_pkg::PULSE_PERIOD_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Control
   input wire logic run,
   output logic tick
);
   logic [31:0] count;
   // Counter restarts whenever the timer is stopped
   always_ff @(posedge core_clk)
   begin
      if (!resetn || !run || tick)
         count <= 32'h0;
      else
         count <= count + 32'h1;
   end
   assign tick = run && (count == 32'(PERIOD - 1));
endmodule
`default_nettype wire

// ==== phy_power_mode_control.sv ====
// Power-mode controller: management bits, mode state and block enables
`default_nettype none
module phy_power_mode_control #(
   parameter int PULSE_PERIOD = pwr_pkg::PULSE_PERIOD_CYCLES,
   parameter int RESET_LEN = pwr_pkg::SOFT_RESET_CYCLES
) (
   // Clock and reset: the management clock domain, alive in every mode
   input wire logic core_clk,
   input wire logic resetn,
   // Register writes from the management frame decoder
   input wire pwr_pkg::reg_write_t reg_write,
   // Line status from the same domain
   input wire logic autoneg_enable,
   input wire logic link_up,
   // Bit readback
   output logic power_down,
   output logic pll_auto_off,
   output logic slow_osc,
   output logic sleep_disable_n,
   output logic power_save,
   // Block enables and status
   output pwr_pkg::block_enable_t block_enable,
   output logic link_pulse,
   output logic soft_reset,
   output pwr_pkg::power_state_t power_state
);
   pwr_pkg::power_state_t state;
   pwr_pkg::power_state_t next_state;
   logic [15:0] reset_count;
   logic hit_basic;
   logic hit_op;
   logic hit_osc;
   logic hit_sleep;
   logic hit_ctrl2;
   logic reset_req;
   logic idle_line;
   logic save_active;
   logic sleep_active;
   logic reset_done;

   // ==========================================================
   // Address decode; all register logic runs on core_clk, the management
   // clock, so writes land even while the PLL is stopped
   assign hit_basic = reg_write.valid && (reg_write.addr == pwr_pkg::REG_BASIC_CTRL);
   assign hit_op = reg_write.valid && (reg_write.addr == pwr_pkg::REG_OP_MODE);
   assign hit_osc = reg_write.valid && (reg_write.addr == pwr_pkg::REG_OSC_CTRL);
   assign hit_sleep = reg_write.valid && (reg_write.addr == pwr_pkg::REG_SLEEP_CTRL);
   assign hit_ctrl2 = reg_write.valid && (reg_write.addr == pwr_pkg::REG_PHY_CTRL2);
   assign reset_req = hit_basic && reg_write.data[pwr_pkg::BIT_SOFT_RESET];

   // ==========================================================
   // Control bits; power-save and sleep come up disabled
   always_ff @(posedge core_clk)
   begin
      if (!resetn || state == pwr_pkg::ST_SOFT_RESET)
      begin
         power_down <= pwr_pkg::RST_POWER_DOWN;
         pll_auto_off <= pwr_pkg::RST_PLL_AUTO_OFF;
         slow_osc <= pwr_pkg::RST_SLOW_OSC;
         sleep_disable_n <= pwr_pkg::RST_SLEEP_DISABLE_N;
         power_save <= pwr_pkg::RST_POWER_SAVE;
      end
      else
      begin
         if (hit_basic)
            power_down <= reg_write.data[pwr_pkg::BIT_POWER_DOWN];
         if (hit_op)
            pll_auto_off <= reg_write.data[pwr_pkg::BIT_PLL_AUTO_OFF];
         if (hit_osc)
            slow_osc <= reg_write.data[pwr_pkg::BIT_SLOW_OSC];
         if (hit_sleep)
            sleep_disable_n <= reg_write.data[pwr_pkg::BIT_SLEEP_DISABLE_N];
         if (hit_ctrl2)
            power_save <= reg_write.data[pwr_pkg::BIT_POWER_SAVE];
      end
   end

   // ==========================================================
   // Mode qualification: low-power line modes only when unplugged
   assign idle_line = autoneg_enable && !link_up;
   assign save_active = power_save && idle_line;
   assign sleep_active = !sleep_disable_n && idle_line;
   assign reset_done = (reset_count == 16'(RESET_LEN - 1));

   // Power-down wins over line modes; reset wins over everything.
   // The documented exit order is left to software: soft reset only
   // clears the bits, it does not check the order was kept
   always_comb
   begin
      next_state = state;
      case (state)
         pwr_pkg::ST_SOFT_RESET:
            next_state = reset_done ? pwr_pkg::ST_NORMAL : pwr_pkg::ST_SOFT_RESET;
         default:
         begin
            if (reset_req)
               next_state = pwr_pkg::ST_SOFT_RESET;
            else if (power_down)
               next_state = pwr_pkg::ST_POWER_DOWN;
            else if (sleep_active)
               next_state = pwr_pkg::ST_SLEEP;
            else if (save_active)
               next_state = pwr_pkg::ST_POWER_SAVE;
            else
               next_state = pwr_pkg::ST_NORMAL;
         end
      endcase
   end

   // State register and soft reset length counter
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         state <= pwr_pkg::ST_NORMAL;
         reset_count <= 16'h0;
      end
      else
      begin
         state <= next_state;
         reset_count <= (state == pwr_pkg::ST_SOFT_RESET) ? reset_count + 16'h1 : 16'h0;
      end
   end

   // ==========================================================
   // Block enables per mode
   always_comb
   begin
      block_enable = '1;
      block_enable.slow_osc_sel = slow_osc;
      case (state)
         pwr_pkg::ST_POWER_SAVE:
         begin
            block_enable.receiver = 1'b0;
            block_enable.digital_core = 1'b0;
         end
         pwr_pkg::ST_SLEEP:
         begin
            block_enable.receiver = 1'b0;
            block_enable.digital_core = 1'b0;
            block_enable.pll = !pll_auto_off;
         end
         pwr_pkg::ST_POWER_DOWN:
         begin
            // Everything off but management; with slow oscillator lowest
            block_enable.transmitter = 1'b0;
            block_enable.energy_detect = 1'b0;
            block_enable.pll = 1'b0;
            block_enable.receiver = 1'b0;
            block_enable.digital_core = 1'b0;
         end
         default:
            block_enable.slow_osc_sel = slow_osc;
      endcase
   end

   // Sleep keeps a periodic link pulse so two sleeping ends can wake
   pulse_timer #(
      .PERIOD(PULSE_PERIOD)
   ) u_pulse_timer (
      .core_clk(core_clk),
      .resetn(resetn),
      .run(state == pwr_pkg::ST_SLEEP),
      .tick(link_pulse)
   );

   assign soft_reset = (state == pwr_pkg::ST_SOFT_RESET);
   assign power_state = state;
endmodule
`default_nettype wire

// ==== mgmt_model.sv ====
// Management controller model issuing single register writes
`default_nettype none
module mgmt_model (
   // Clock and write strobe
   input wire logic core_clk,
   output pwr_pkg::reg_write_t reg_write
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle fields start at zero, then show inverted junk after each write so a stale word is never mistaken for data
   initial reg_write = '0;
   task automatic put(input logic [4:0] a, input logic [15:0] d);
      @(negedge core_clk);
      reg_write = {1'b1, a, d};
      @(negedge core_clk);
      reg_write = {1'b0, ~a, ~d};
   endtask
endmodule
`default_nettype wire

// ==== pwr_checker.sv ====
// Port-level checks of the power-mode controller
`default_nettype none
module pwr_checker #(
   parameter int PULSE_PERIOD = 8,
   parameter int RESET_LEN = 4
) (
   // Clock, reset and inputs
   input wire logic core_clk,
   input wire logic resetn,
   input wire pwr_pkg::reg_write_t reg_write,
   input wire logic autoneg_enable,
   input wire logic link_up,
   // Outputs
   input wire logic power_down,
   input wire logic pll_auto_off,
   input wire logic slow_osc,
   input wire logic sleep_disable_n,
   input wire logic power_save,
   input wire pwr_pkg::block_enable_t block_enable,
   input wire logic link_pulse,
   input wire logic soft_reset,
   input wire pwr_pkg::power_state_t power_state
);
   timeunit 1ns;
   timeprecision 1ps;
   int hi_len;
   int gap;
   wire logic quiet;
   wire logic wr;
   // Writes only land outside soft reset
   assign quiet = !soft_reset && power_state != pwr_pkg::ST_SOFT_RESET;
   assign wr = reg_write.valid && quiet;
   // Counters: soft reset length, and sleep cycles since the last pulse
   always_ff @(posedge core_clk)
   begin
      hi_len <= soft_reset ? hi_len + 1 : 0;
      gap <= (link_pulse || power_state != pwr_pkg::ST_SLEEP) ? 0 : gap + 1;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // ==========================================================
   // Bit writes and mode causes
   chk_save_write: assert property (wr && reg_write.addr == pwr_pkg::REG_PHY_CTRL2
      |=> power_save == $past(reg_write.data[10])) else $error("power save bit wrong");
   chk_down_write: assert property (wr && reg_write.addr == pwr_pkg::REG_BASIC_CTRL
      && !reg_write.data[15] |=> power_down == $past(reg_write.data[11]))
      else $error("power down bit wrong");
   chk_save_cause: assert property (power_state == pwr_pkg::ST_POWER_SAVE
      |-> $past(power_save && autoneg_enable && !link_up)) else $error("bad power save");
   chk_sleep_cause: assert property (power_state == pwr_pkg::ST_SLEEP
      |-> $past(!sleep_disable_n && autoneg_enable && !link_up)) else $error("bad sleep");
   chk_down_cause: assert property (power_state == pwr_pkg::ST_POWER_DOWN
      |-> $past(power_down)) else $error("power down without bit");
   // ==========================================================
   // Block enables per mode, and link pulse gap in sleep
   chk_down_blocks: assert property (power_state == pwr_pkg::ST_POWER_DOWN
      |-> block_enable[5:1] == 5'h00) else $error("blocks alive in power down");
   chk_save_blocks: assert property (power_state == pwr_pkg::ST_POWER_SAVE
      |-> block_enable[5:1] == 5'h1C) else $error("power save enables wrong");
   chk_sleep_blocks: assert property (power_state == pwr_pkg::ST_SLEEP
      |-> block_enable[5:1] == {2'h3, !pll_auto_off, 2'h0}) else $error("sleep enables wrong");
   chk_pulse_gap: assert property (gap <= PULSE_PERIOD + 1)
      else $error("link pulse missing in sleep");
   // ==========================================================
   // Soft reset
   chk_reset_len: assert property ($fell(soft_reset) |-> hi_len == RESET_LEN)
      else $error("soft reset length wrong");
   chk_reset_bits: assert property ($past(soft_reset) && soft_reset
      |-> !power_down && !pll_auto_off && !slow_osc && !power_save && sleep_disable_n)
      else $error("bits not cleared in soft reset");
endmodule
bind phy_power_mode_control pwr_checker #(.PULSE_PERIOD(PULSE_PERIOD), .RESET_LEN(RESET_LEN))
   i_pwr_checker (.core_clk(core_clk), .resetn(resetn), .reg_write(reg_write),
   .autoneg_enable(autoneg_enable), .link_up(link_up), .power_down(power_down),
   .pll_auto_off(pll_auto_off), .slow_osc(slow_osc), .sleep_disable_n(sleep_disable_n),
   .power_save(power_save), .block_enable(block_enable), .link_pulse(link_pulse),
   .soft_reset(soft_reset), .power_state(power_state));
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench of the power-mode controller
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
   $display("BAD %0t %h %h", $time, a, b); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk;
   logic resetn;
   logic autoneg_enable;
   logic link_up;
   pwr_pkg::reg_write_t reg_write;
   logic power_down, pll_auto_off, slow_osc, sleep_disable_n, power_save, link_pulse, soft_reset;
   pwr_pkg::block_enable_t block_enable;
   pwr_pkg::power_state_t power_state;
   int fail_count = 0;
   int n_compared = 0;
   int cycles = 0;
   int pulses = 0;
   // Short pulse period and reset length keep the run brief
   phy_power_mode_control #(.PULSE_PERIOD(8), .RESET_LEN(4)) i_phy_power_mode_control (
      .core_clk(core_clk), .resetn(resetn), .reg_write(reg_write),
      .autoneg_enable(autoneg_enable), .link_up(link_up), .power_down(power_down),
      .pll_auto_off(pll_auto_off), .slow_osc(slow_osc), .sleep_disable_n(sleep_disable_n),
      .power_save(power_save), .block_enable(block_enable), .link_pulse(link_pulse),
      .soft_reset(soft_reset), .power_state(power_state));
   mgmt_model i_mgmt_model (.core_clk(core_clk), .reg_write(reg_write));
   // Clock, pulse count sampled where settled, and hang guard
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   always @(negedge core_clk) if (link_pulse === 1'b1) pulses++;
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fail_count++;
         complete_run();
      end
   end
   task automatic wt(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic complete_run();
      if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      `CHK({power_down, pll_auto_off, slow_osc, sleep_disable_n, power_save}, 5'h02)
      `CHK(block_enable, 6'h3E)
   endtask
   task automatic t_save();
      i_mgmt_model.put(pwr_pkg::REG_PHY_CTRL2, 16'h0400);
      `CHK(power_save, 1'b1)
      wt(1);
      `CHK(power_state, pwr_pkg::ST_NORMAL)
      link_up = 1'b0;
      wt(2);
      `CHK(power_state, pwr_pkg::ST_POWER_SAVE)
      `CHK(block_enable, 6'h38)
   endtask
   task automatic t_sleep();
      i_mgmt_model.put(pwr_pkg::REG_OP_MODE, 16'h0010);
      i_mgmt_model.put(pwr_pkg::REG_SLEEP_CTRL, 16'h0000);
      `CHK(sleep_disable_n, 1'b0)
      wt(1);
      `CHK(power_state, pwr_pkg::ST_SLEEP)
      `CHK(block_enable, 6'h30)
      pulses = 0;
      wt(20);
      `CHK(pulses inside {2, 3}, 1'b1)
      autoneg_enable = 1'b0;
      wt(2);
      `CHK(power_state, pwr_pkg::ST_NORMAL)
      autoneg_enable = 1'b1;
   endtask
   task automatic t_down();
      int n;
      i_mgmt_model.put(pwr_pkg::REG_OSC_CTRL, 16'h0020);
      i_mgmt_model.put(pwr_pkg::REG_BASIC_CTRL, 16'h0800);
      wt(1);
      `CHK(power_state, pwr_pkg::ST_POWER_DOWN)
      `CHK({slow_osc, block_enable}, 7'h41)
      // Ordered exit: slow clock off, power-down off, then soft reset
      i_mgmt_model.put(pwr_pkg::REG_OSC_CTRL, 16'h0000);
      `CHK(slow_osc, 1'b0)
      i_mgmt_model.put(pwr_pkg::REG_BASIC_CTRL, 16'h0000);
      wt(1);
      `CHK(power_state, pwr_pkg::ST_SLEEP)
      i_mgmt_model.put(pwr_pkg::REG_BASIC_CTRL, 16'h8000);
      wt(1);
      `CHK({soft_reset, power_save, sleep_disable_n}, 3'h5)
      n = 0;
      while (soft_reset === 1'b1 && n < 20)
      begin
         n++;
         wt(1);
      end
      wt(2);
      `CHK(power_state, pwr_pkg::ST_NORMAL)
   endtask
   // ==========================================================
   // Main sequence
   initial
   begin
      resetn = 1'b0;
      autoneg_enable = 1'b1;
      link_up = 1'b1;
      wt(10);
      resetn = 1'b1;
      wt(1);
      t_reset();
      t_save();
      t_sleep();
      t_down();
      complete_run();
   end
endmodule
`default_nettype wire
